// ### fsp_fault_supervisor.sv
// fault supervision, alarm output and power modes of the gate driver
// Behaviour
// - warning temperature sets the warning flag, and the alarm only with report select 1; gates keep driving.
// - warning flag clears by itself once temperature drops below hysteresis.
// - report select 1 puts warning on alarm pin and summary; 0 leaves it in the status warning bit only.
// - thermal shutdown: gates off, pump stopped, alarm low, summary and shutdown flags set.
// - after thermal shutdown, gates and alarm recover automatically when temperature drops.
// - shutdown flag stays set until register clear, enable reset pulse or sleep.
// - thermal shutdown protection can never be disabled.
// - motor or drain supply low: alarm, gates high impedance, automatic recovery.
// - pump or lowside regulator low acts like unless the check-off bit is 1.
// - drain-source overcurrent follows mode: latch, retry, report only, nothing.
// - shunt overcurrent uses the same four mode responses.
// - shunt overcurrent ignored when mode is 11 or shunt check-off is 1.
// - stuck gate latches alarm and high impedance until cleared unless check-off set.
// - enable low sleeps: gates, pump, regulators, amplifiers and serial port off.
// - entering sleep returns every register to its default.
// - sleep starts only after the sleep delay from enable falling.
// - enable high wakes the device; controller waits the wake delay.
// - in sleep or motor lockout all transistors held off by pulldowns.
// - enable high and motor supply good gives operating mode after wake delay.
// - enable reset pulse clears latched faults only, nothing else.
`timescale 1ns/1ps
module fsp_fault_supervisor #(
	parameter int unsigned RETRY_CYCLES = fsp_pkg::RETRY_CYC,
	parameter int unsigned WAKE_CYCLES  = fsp_pkg::WAKE_CYC
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// pins and monitor comparators
	input  wire logic        enable_pin,
	input  wire logic        overheat_warning,
	input  wire logic        overheat_shutdown,
	input  wire logic        motor_supply_low,
	input  wire logic        drain_sense_supply_low,
	input  wire logic        pump_supply_low,
	input  wire logic        lowside_reg_low,
	input  wire logic        drain_source_overcurrent,
	input  wire logic        shunt_overcurrent,
	input  wire logic        gate_stuck_error,
	input  wire logic        alarm_out_n_i,
	output logic             alarm_out_n_o,
	output logic             alarm_out_n_oe,
	// actions
	output logic             gate_hiz,
	output logic             gate_hold_off,
	output logic             charge_pump_en,
	output logic             lowside_reg_en,
	output logic             logic_reg_en,
	output logic             sense_amp_en,
	output logic             serial_port_en,
	output logic             ready
);
	localparam int TW = fsp_pkg::TMR_W;

	// word select shared by read and write decode
	function automatic logic fsp_hit(input logic [7:0] a, input logic [7:0] reg_addr);
		fsp_hit = (a[7:2] == reg_addr[7:2]);
	endfunction : fsp_hit

	logic                          rs1_reg;
	logic                          rs_n;
	fsp_pkg::fsp_state_t           state_reg;
	fsp_pkg::fsp_state_t           state_next;
	logic [fsp_pkg::CTRL_W-1:0]    ctrl_reg;
	logic [TW-1:0]                 retry_reg;
	logic [TW-1:0]                 sleep_reg;
	logic                          en_prev_reg;
	logic                          tsd_flag_reg;
	logic                          ds_flag_reg;
	logic                          sh_flag_reg;
	logic                          stuck_flag_reg;
	logic                          wr_pend_reg;
	logic                          rd_pend_reg;
	logic [7:0]                    addr_reg;
	logic                          sleep_busy;
	logic                          sleep_done;
	logic                          wake_done;
	logic                          rstwin_busy;
	logic                          retry_done;

	// reset release through two flops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rs1_reg <= 1'b0;
			rs_n    <= 1'b0;
		end else begin
			rs1_reg <= 1'b1;
			rs_n    <= rs1_reg;
		end
	end

	// enable pin edges and power state decode
	wire en_fall   = en_prev_reg & ~enable_pin;
	wire en_rise   = ~en_prev_reg & enable_pin;
	wire asleep    = (state_reg == fsp_pkg::PS_SLEEP);
	wire running   = (state_reg == fsp_pkg::PS_RUN);
	wire operating = ~asleep & ~motor_supply_low;

	// configuration fields
	wire                 rep_sel   = ctrl_reg[fsp_pkg::CTRL_REP];
	wire                 gduv_off  = ctrl_reg[fsp_pkg::CTRL_GDUV_OFF];
	wire                 shunt_off = ctrl_reg[fsp_pkg::CTRL_SHUNT_OFF];
	wire                 stuck_off = ctrl_reg[fsp_pkg::CTRL_STUCK_OFF];
	fsp_pkg::fsp_mode_t  pmode;
	assign pmode = fsp_pkg::fsp_mode_t'(ctrl_reg[fsp_pkg::CTRL_MODE_LO +: 2]);

	// bus address phase and write data phase decode
	wire                 take      = hsel & hready & htrans[1];
	wire                 wr_ok     = wr_pend_reg & ~asleep;
	wire                 wr_ctrl   = wr_ok & fsp_hit(addr_reg, fsp_pkg::ADDR_CTRL);
	wire                 wr_retry  = wr_ok & fsp_hit(addr_reg, fsp_pkg::ADDR_RETRY);
	wire                 wr_sleep  = wr_ok & fsp_hit(addr_reg, fsp_pkg::ADDR_SLEEP);
	wire                 clr_bit   = wr_ctrl & hwdata[fsp_pkg::CTRL_CLEAR];

	// clear command from register or from a short enable low pulse
	wire pin_clear = en_rise & rstwin_busy & ~asleep;
	wire clear_cmd = clr_bit | pin_clear;

	// fault qualification by configuration
	wire gduv_hit  = (pump_supply_low | lowside_reg_low) & ~gduv_off;
	wire sup_hit   = motor_supply_low | drain_sense_supply_low;
	wire ds_hit    = drain_source_overcurrent & (pmode != fsp_pkg::PM_NONE);
	wire sh_hit    = shunt_overcurrent & (pmode != fsp_pkg::PM_NONE) & ~shunt_off;
	wire stuck_hit = gate_stuck_error & ~stuck_off;
	wire ocp_stops = (pmode == fsp_pkg::PM_LATCH) | (pmode == fsp_pkg::PM_RETRY);
	wire ocp_clear = (pmode == fsp_pkg::PM_RETRY) ? retry_done : clear_cmd;
	wire retry_go  = (ds_hit | sh_hit) & (pmode == fsp_pkg::PM_RETRY) & ~asleep;

	// next values of the fault flags, a new event wins over a clear
	wire tsd_next   = ~asleep & (overheat_shutdown | (tsd_flag_reg & ~clear_cmd));
	wire ds_next    = ~asleep & (ds_hit | (ds_flag_reg & ~ocp_clear));
	wire sh_next    = ~asleep & (sh_hit | (sh_flag_reg & ~ocp_clear));
	wire stuck_next = ~asleep & (stuck_hit | (stuck_flag_reg & ~clear_cmd));

	// gate release, alarm and summary
	wire hiz_next   = ~asleep & (overheat_shutdown | sup_hit | gduv_hit | stuck_next
	                  | (ocp_stops & (ds_next | sh_next)));
	wire warn_rep   = overheat_warning & rep_sel;
	wire alarm_next = ~asleep & (overheat_shutdown | sup_hit | gduv_hit | ds_next
	                  | sh_next | stuck_next | warn_rep);
	wire summary    = alarm_out_n_oe | tsd_flag_reg;

	// power state sequencing
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			fsp_pkg::PS_SLEEP: begin
				if (enable_pin) begin
					state_next = fsp_pkg::PS_WAKE;
				end
			end
			fsp_pkg::PS_WAKE: begin
				if (sleep_done) begin
					state_next = fsp_pkg::PS_SLEEP;
				end else if (wake_done) begin
					state_next = fsp_pkg::PS_RUN;
				end
			end
			fsp_pkg::PS_RUN: begin
				if (sleep_done) begin
					state_next = fsp_pkg::PS_SLEEP;
				end
			end
			default: begin
				state_next = fsp_pkg::PS_SLEEP;
			end
		endcase
	end

	// delay after enable falls before sleeping
	fsp_delay_timer #(.W(TW)) u_sleep_tmr (
		.clk   (clk),
		.rst_n (rs_n),
		.start (en_fall & ~asleep),
		.abort (en_rise),
		.load  (sleep_reg),
		.busy  (sleep_busy),
		.done  (sleep_done)
	);

	// wake delay before the device takes inputs
	fsp_delay_timer #(.W(TW)) u_wake_tmr (
		.clk   (clk),
		.rst_n (rs_n),
		.start (asleep & enable_pin),
		.abort (asleep),
		.load  (TW'(WAKE_CYCLES)),
		.busy  (),
		.done  (wake_done)
	);

	// window in which an enable low pulse counts as a reset pulse
	fsp_delay_timer #(.W(TW)) u_rstwin_tmr (
		.clk   (clk),
		.rst_n (rs_n),
		.start (en_fall & ~asleep),
		.abort (asleep),
		.load  (TW'(fsp_pkg::RSTWIN_CYC)),
		.busy  (rstwin_busy),
		.done  ()
	);

	// retry period of overcurrent in retry mode, restarted by each event
	fsp_delay_timer #(.W(TW)) u_retry_tmr (
		.clk   (clk),
		.rst_n (rs_n),
		.start (retry_go),
		.abort (asleep),
		.load  (retry_reg),
		.busy  (),
		.done  (retry_done)
	);

	// state and enable history
	always_ff @(posedge clk or negedge rs_n) begin
		if (!rs_n) begin
			state_reg   <= fsp_pkg::PS_SLEEP;
			en_prev_reg <= 1'b0;
		end else begin
			state_reg   <= state_next;
			en_prev_reg <= enable_pin;
		end
	end

	// software registers, returned to defaults while asleep
	always_ff @(posedge clk or negedge rs_n) begin
		if (!rs_n) begin
			ctrl_reg  <= fsp_pkg::CTRL_RST;
			retry_reg <= TW'(RETRY_CYCLES);
			sleep_reg <= fsp_pkg::SLEEP_RST;
		end else if (asleep) begin
			ctrl_reg  <= fsp_pkg::CTRL_RST;
			retry_reg <= TW'(RETRY_CYCLES);
			sleep_reg <= fsp_pkg::SLEEP_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= hwdata[fsp_pkg::CTRL_W-1:0];
			end
			if (wr_retry) begin
				retry_reg <= hwdata;
			end
			if (wr_sleep) begin
				sleep_reg <= hwdata;
			end
		end
	end

	// latched fault flags
	always_ff @(posedge clk or negedge rs_n) begin
		if (!rs_n) begin
			tsd_flag_reg   <= 1'b0;
			ds_flag_reg    <= 1'b0;
			sh_flag_reg    <= 1'b0;
			stuck_flag_reg <= 1'b0;
		end else begin
			tsd_flag_reg   <= tsd_next;
			ds_flag_reg    <= ds_next;
			sh_flag_reg    <= sh_next;
			stuck_flag_reg <= stuck_next;
		end
	end

	// registered pin and enable outputs
	always_ff @(posedge clk or negedge rs_n) begin
		if (!rs_n) begin
			alarm_out_n_o  <= 1'b0;
			alarm_out_n_oe <= 1'b0;
			gate_hiz       <= 1'b0;
			gate_hold_off  <= 1'b1;
			charge_pump_en <= 1'b0;
			lowside_reg_en <= 1'b0;
			logic_reg_en   <= 1'b0;
			sense_amp_en   <= 1'b0;
			serial_port_en <= 1'b0;
			ready          <= 1'b0;
		end else begin
			alarm_out_n_o  <= 1'b0;
			alarm_out_n_oe <= alarm_next;
			gate_hiz       <= hiz_next;
			gate_hold_off  <= ~(state_next == fsp_pkg::PS_RUN) | motor_supply_low;
			charge_pump_en <= operating & ~overheat_shutdown;
			lowside_reg_en <= operating;
			logic_reg_en   <= ~asleep;
			sense_amp_en   <= ~asleep;
			serial_port_en <= ~asleep;
			ready          <= (state_next == fsp_pkg::PS_RUN) & ~motor_supply_low;
		end
	end

	// status word: warning flag follows the comparator directly
	wire [31:0] stat_word = {19'h00000,
		alarm_out_n_i, ready, gate_hiz, stuck_flag_reg, sh_flag_reg,
		ds_flag_reg, lowside_reg_low & ~asleep, pump_supply_low & ~asleep,
		drain_sense_supply_low & ~asleep, motor_supply_low,
		tsd_flag_reg, overheat_warning & ~asleep, summary};

	// read mux, unmapped words read zero
	wire [31:0] rd_mux =
		fsp_hit(addr_reg, fsp_pkg::ADDR_CTRL)  ? {26'h0000000, ctrl_reg} :
		fsp_hit(addr_reg, fsp_pkg::ADDR_STAT)  ? stat_word :
		fsp_hit(addr_reg, fsp_pkg::ADDR_RETRY) ? retry_reg :
		fsp_hit(addr_reg, fsp_pkg::ADDR_SLEEP) ? sleep_reg : 32'h00000000;

	// bus phases: writes take no wait, reads take one wait state
	always_ff @(posedge clk or negedge rs_n) begin
		if (!rs_n) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg    <= 8'h00;
			hreadyout   <= 1'b1;
			hrdata      <= 32'h00000000;
			hresp       <= 1'b0;
		end else begin
			hresp       <= 1'b0;
			wr_pend_reg <= take & hwrite;
			rd_pend_reg <= take & ~hwrite;
			if (take) begin
				addr_reg <= haddr[7:0];
			end
			if (take & ~hwrite) begin
				hreadyout <= 1'b0;
			end else begin
				hreadyout <= 1'b1;
			end
			if (rd_pend_reg) begin
				hrdata <= rd_mux;
			end
		end
	end

	// hsize is always a word here
	wire unused_ok = &{1'b0, hsize, haddr[31:8], sleep_busy};
endmodule : fsp_fault_supervisor

// ### fsp_pkg.sv
// shared constants and types of the fault supervisor
package fsp_pkg;
	// clock and delay figures
	localparam int unsigned CLK_HZ     = 25_000_000;
	localparam int unsigned RETRY_MS   = 8;
	localparam int unsigned SLEEP_US   = 100;
	localparam int unsigned WAKE_US    = 1000;
	localparam int unsigned RSTWIN_US  = 40;
	localparam int unsigned RETRY_CYC  = RETRY_MS * (CLK_HZ / 1000);
	localparam int unsigned SLEEP_CYC  = SLEEP_US * (CLK_HZ / 1_000_000);
	localparam int unsigned WAKE_CYC   = WAKE_US * (CLK_HZ / 1_000_000);
	localparam int unsigned RSTWIN_CYC = RSTWIN_US * (CLK_HZ / 1_000_000);
	localparam int          TMR_W      = 32;

	// register byte addresses
	localparam logic [7:0] ADDR_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_STAT  = 8'h04;
	localparam logic [7:0] ADDR_RETRY = 8'h08;
	localparam logic [7:0] ADDR_SLEEP = 8'h0C;

	// control register fields
	localparam int CTRL_REP       = 0;
	localparam int CTRL_GDUV_OFF  = 1;
	localparam int CTRL_SHUNT_OFF = 2;
	localparam int CTRL_STUCK_OFF = 3;
	localparam int CTRL_MODE_LO   = 4;
	localparam int CTRL_CLEAR     = 6;
	localparam int CTRL_W         = 6;
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
	localparam logic [TMR_W-1:0]  SLEEP_RST = 32'(SLEEP_CYC);

	// status register fields
	localparam int ST_SUMMARY = 0;
	localparam int ST_WARN    = 1;
	localparam int ST_TSD     = 2;
	localparam int ST_MS_LOW  = 3;
	localparam int ST_DR_LOW  = 4;
	localparam int ST_CP_LOW  = 5;
	localparam int ST_LS_LOW  = 6;
	localparam int ST_DS_OCP  = 7;
	localparam int ST_SH_OCP  = 8;
	localparam int ST_STUCK   = 9;
	localparam int ST_HIZ     = 10;
	localparam int ST_READY   = 11;
	localparam int ST_PIN     = 12;

	typedef enum logic [1:0] {
		PM_LATCH  = 2'h0,
		PM_RETRY  = 2'h1,
		PM_REPORT = 2'h2,
		PM_NONE   = 2'h3
	} fsp_mode_t;

	typedef enum logic [2:0] {
		PS_SLEEP = 3'h1,
		PS_WAKE  = 3'h2,
		PS_RUN   = 3'h4
	} fsp_state_t;
endpackage : fsp_pkg

// ### fsp_delay_timer.sv
// loadable down counter that times one delay
`timescale 1ns/1ps
module fsp_delay_timer #(
	parameter int W = 32
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         start,
	input  wire logic         abort,
	input  wire logic [W-1:0] load,
	output logic              busy,
	output logic              done
);
	logic [W-1:0] cnt_reg;
	wire          last = (cnt_reg <= W'(1));

	// start restarts the delay, done pulses once after load cycles
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
			busy    <= 1'b0;
			done    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				cnt_reg <= load;
				busy    <= 1'b1;
			end else if (abort) begin
				busy <= 1'b0;
			end else if (busy) begin
				cnt_reg <= cnt_reg - W'(1);
				if (last) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule : fsp_delay_timer

// ### fsp_fault_supervisor_chk.sv
// port checker of the fault supervisor, bound to the design top
`timescale 1ns/1ps
module fsp_fault_supervisor_chk #(
	parameter int unsigned RETRY_CYCLES = fsp_pkg::RETRY_CYC,
	parameter int unsigned WAKE_CYCLES  = fsp_pkg::WAKE_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic enable_pin,
	input wire logic overheat_shutdown,
	input wire logic motor_supply_low,
	input wire logic drain_sense_supply_low,
	input wire logic alarm_out_n_oe,
	input wire logic gate_hiz,
	input wire logic gate_hold_off,
	input wire logic charge_pump_en,
	input wire logic lowside_reg_en,
	input wire logic logic_reg_en,
	input wire logic sense_amp_en,
	input wire logic serial_port_en,
	input wire logic ready
);
	int   wcnt;
	logic fresh;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// cycles spent waking, and whether the wake started from sleep
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wcnt  <= 0;
			fresh <= 1'b1;
		end else begin
			wcnt  <= (!logic_reg_en || ready) ? 0 : wcnt + 1;
			fresh <= !logic_reg_en || (fresh && !ready);
		end
	end
	property p_tsd;
		ready && overheat_shutdown |-> ##[1:2] (alarm_out_n_oe && gate_hiz && !charge_pump_en);
	endproperty
	a_tsd: assert property (p_tsd) else $error("shutdown left drive on");
	property p_drain;
		ready && drain_sense_supply_low |-> ##[1:2] (alarm_out_n_oe && gate_hiz);
	endproperty
	a_drain: assert property (p_drain) else $error("supply low not acted on");
	property p_lock;
		motor_supply_low |-> ##[1:2] gate_hold_off;
	endproperty
	a_lock: assert property (p_lock) else $error("lockout left transistors on");
	property p_sleep;
		!logic_reg_en |-> gate_hold_off && !charge_pump_en && !lowside_reg_en
			&& !sense_amp_en && !serial_port_en && !ready;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep left a block on");
	property p_sleep_wait;
		ready && $fell(enable_pin) |=> logic_reg_en [*8];
	endproperty
	a_sleep_wait: assert property (p_sleep_wait) else $error("slept too early");
	property p_wake;
		$rose(ready) && fresh |-> wcnt >= WAKE_CYCLES - 1 && wcnt <= WAKE_CYCLES + 3;
	endproperty
	a_wake: assert property (p_wake) else $error("wake delay wrong");
	property p_run;
		$rose(ready) |-> logic_reg_en && serial_port_en && lowside_reg_en && !gate_hold_off;
	endproperty
	a_run: assert property (p_run) else $error("operating mode incomplete");
	property p_pulse;
		ready && $rose(enable_pin) |=> ready [*4];
	endproperty
	a_pulse: assert property (p_pulse) else $error("reset pulse disturbed mode");
endmodule : fsp_fault_supervisor_chk
bind fsp_fault_supervisor fsp_fault_supervisor_chk #(
	.RETRY_CYCLES(RETRY_CYCLES),
	.WAKE_CYCLES (WAKE_CYCLES)
) i_fsp_fault_supervisor_chk (
	.clk, .rstn, .enable_pin, .overheat_shutdown, .motor_supply_low,
	.drain_sense_supply_low, .alarm_out_n_oe, .gate_hiz, .gate_hold_off,
	.charge_pump_en, .lowside_reg_en, .logic_reg_en, .sense_amp_en,
	.serial_port_en, .ready
);

// ### fsp_ctrl_model.sv
// far-side controller: enable pin, reset pulses, pulled-up alarm wire
`timescale 1ns/1ps
module fsp_ctrl_model #(
	parameter int PULSE_CYC = 5
) (
	input  wire logic clk,
	input  wire logic en_req,
	input  wire logic pulse_go,
	input  wire logic alarm_o,
	input  wire logic alarm_oe,
	output logic      enable_pin,
	output logic      alarm_n
);
	int low_cnt = 0;
	initial enable_pin = 1'b0;
	// pull-up wins whenever nobody pulls the alarm line low
	assign alarm_n = alarm_oe ? alarm_o : 1'b1;
	// low pulse kept short, well inside the reset window
	always @(posedge clk) begin
		if (pulse_go)
			low_cnt <= PULSE_CYC;
		else if (low_cnt > 0)
			low_cnt <= low_cnt - 1;
		enable_pin <= en_req && !(pulse_go || low_cnt > 1);
	end
endmodule : fsp_ctrl_model

// ### fsp_fault_supervisor_tb_top.sv
// self-checking bench of the fault supervisor with its controller model
`timescale 1ns/1ps
module fsp_fault_supervisor_tb_top;
	localparam int RTY = 20;
	localparam int WK  = 10;
	logic        clk = 1'b0, rstn = 1'b0, hwrite = 1'b0, en_req = 1'b0, pulse_go = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
	logic [1:0]  htrans = 2'h0, x;
	logic [8:0]  flt = 9'h000;
	wire         hreadyout, oe, od, alarm_n, enable_pin, hiz, hold, cp, rdy, resp;
	wire  [3:0]  en4;
	wire  [31:0] hrdata;
	int          bad_count = 0, checks_done = 0, n;
	bit          off;
	always #20 clk = ~clk;
	fsp_fault_supervisor #(.RETRY_CYCLES(RTY), .WAKE_CYCLES(WK)) i_fsp_fault_supervisor (
		.clk(clk), .rstn(rstn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(resp), .enable_pin(enable_pin),
		.overheat_warning(flt[0]), .overheat_shutdown(flt[1]), .motor_supply_low(flt[2]),
		.drain_sense_supply_low(flt[3]), .pump_supply_low(flt[4]),
		.lowside_reg_low(flt[5]), .drain_source_overcurrent(flt[6]),
		.shunt_overcurrent(flt[7]), .gate_stuck_error(flt[8]), .alarm_out_n_i(alarm_n),
		.alarm_out_n_o(od), .alarm_out_n_oe(oe), .gate_hiz(hiz), .gate_hold_off(hold),
		.charge_pump_en(cp), .lowside_reg_en(en4[3]), .logic_reg_en(en4[2]),
		.sense_amp_en(en4[1]), .serial_port_en(en4[0]), .ready(rdy));
	fsp_ctrl_model i_fsp_ctrl_model (.clk(clk), .en_req(en_req), .pulse_go(pulse_go),
		.alarm_o(od), .alarm_oe(oe), .enable_pin(enable_pin), .alarm_n(alarm_n));
	// one single ahb-lite transfer, waiting on hready in both phases
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr  <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic rs(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask : rs
	task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask : cmp
	task automatic pin(input string s, input logic e, input logic g);
		cmp(s, {31'h0, e}, {31'h0, g});
	endtask : pin
	task automatic st(input logic [31:0] e, input logic [31:0] m);
		rs(fsp_pkg::ADDR_STAT);
		cmp("status", e & m, rd & m);
	endtask : st
	task automatic wr(output int c);
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while (rdy !== 1'b1 && c < 200);
		pin("ready wait", 1'b1, rdy);
	endtask : wr
	task automatic fin(input string s);
		$display("test %s done", s);
	endtask : fin
	// expected {gates off, alarm} of an overcurrent or stuck-gate event
	function automatic logic [1:0] exp(int s, int m, bit o, bit late);
		if (o || (m == 3 && s != 8)) return 2'b00;
		if (s == 8) return 2'b11;
		if (m == 2) return 2'b01;
		return (late && m == 1) ? 2'b00 : 2'b11;
	endfunction : exp
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		report_and_stop();
	end
	// main sequence
	initial begin
		void'($urandom(37));
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		bus(1'b1, fsp_pkg::ADDR_SLEEP, 32'h7);
		rs(fsp_pkg::ADDR_SLEEP);
		cmp("sleep count", fsp_pkg::SLEEP_RST, rd);
		rs(fsp_pkg::ADDR_RETRY);
		cmp("retry count", 32'(RTY), rd);
		fin("reset");
		en_req <= 1'b1;
		wr(n);
		pin("wake delay", 1'b1, n >= WK && n <= WK + 8);
		bus(1'b1, fsp_pkg::ADDR_SLEEP, 32'h28);
		bus(1'b1, 8'h40, 32'hFFFF);
		rs(8'h40);
		cmp("unmapped", 32'h0, rd);
		pin("bus response", 1'b0, resp);
		rs(fsp_pkg::ADDR_SLEEP);
		cmp("sleep write", 32'h28, rd);
		fin("wake");
		for (int r = 0; r < 2; r++) begin
			bus(1'b1, fsp_pkg::ADDR_CTRL, 32'(r));
			flt[0] <= 1'b1;
			repeat (3) @(posedge clk);
			pin("warning gates", 1'b0, hiz);
			pin("warning alarm", r == 0, alarm_n);
			st(32'h2 | 32'(r), 32'h403);
			flt[0] <= 1'b0;
			repeat (3) @(posedge clk);
			st(32'h0, 32'h3);
		end
		fin("warning");
		bus(1'b1, fsp_pkg::ADDR_CTRL, 32'h3E);
		flt[1] <= 1'b1;
		repeat (3) @(posedge clk);
		pin("shutdown gates", 1'b1, hiz);
		pin("shutdown pump", 1'b0, cp);
		pin("shutdown alarm", 1'b0, alarm_n);
		flt[1] <= 1'b0;
		repeat (3) @(posedge clk);
		pin("recovered gates", 1'b0, hiz);
		pin("recovered alarm", 1'b1, alarm_n);
		st(32'h5, 32'h5);
		bus(1'b1, fsp_pkg::ADDR_CTRL, 32'h40);
		st(32'h0, 32'h5);
		fin("shutdown");
		for (int i = 2; i < 6; i++)
			for (int o = 0; o < 2; o++) begin
				bus(1'b1, fsp_pkg::ADDR_CTRL, 32'(o << 1));
				flt[i] <= 1'b1;
				repeat (3) @(posedge clk);
				pin("supply alarm", o && i > 3, alarm_n);
				if (i == 2)
					pin("lockout hold", 1'b1, hold);
				else
					pin("supply gates", !(o && i > 3), hiz);
				flt[i] <= 1'b0;
				repeat (3) @(posedge clk);
				wr(n);
				pin("supply recovered", 1'b0, hiz);
			end
		fin("supply");
		for (int s = 6; s < 9; s++)
			for (int m = 0; m < 4; m++) begin
				off = 1'($urandom % 2);
				bus(1'b1, fsp_pkg::ADDR_CTRL,
					{26'h0, 2'(m), off && s == 8, off && s == 7, 2'h0});
				flt[s] <= 1'b1;
				repeat (1 + $urandom % 4) @(posedge clk);
				flt[s] <= 1'b0;
				repeat (2) @(posedge clk);
				x = exp(s, m, off && s != 6, 1'b0);
				pin("event gates", x[1], hiz);
				pin("event alarm", !x[0], alarm_n);
				repeat (RTY + 10) @(posedge clk);
				x = exp(s, m, off && s != 6, 1'b1);
				pin("held gates", x[1], hiz);
				pin("held alarm", !x[0], alarm_n);
				bus(1'b1, fsp_pkg::ADDR_CTRL, 32'h40);
				repeat (2) @(posedge clk);
				pin("cleared alarm", 1'b1, alarm_n);
			end
		fin("overcurrent");
		bus(1'b1, fsp_pkg::ADDR_CTRL, 32'h1);
		flt[6] <= 1'b1;
		@(posedge clk);
		flt[6] <= 1'b0;
		repeat (3) @(posedge clk);
		pin("latched gates", 1'b1, hiz);
		pulse_go <= 1'b1;
		@(posedge clk);
		pulse_go <= 1'b0;
		repeat (10) @(posedge clk);
		pin("pulse gates", 1'b0, hiz);
		pin("pulse awake", 1'b1, rdy);
		rs(fsp_pkg::ADDR_CTRL);
		cmp("kept settings", 32'h1, rd);
		fin("pulse");
		en_req <= 1'b0;
		repeat (20) @(posedge clk);
		pin("sleep wait", 1'b1, rdy);
		repeat (40) @(posedge clk);
		pin("asleep", 1'b0, rdy);
		pin("asleep hold", 1'b1, hold);
		cmp("asleep enables", 32'h0, {27'h0, cp, en4});
		en_req <= 1'b1;
		wr(n);
		rs(fsp_pkg::ADDR_CTRL);
		cmp("ctrl default", 32'(fsp_pkg::CTRL_RST), rd);
		rs(fsp_pkg::ADDR_SLEEP);
		cmp("sleep default", fsp_pkg::SLEEP_RST, rd);
		bus(1'b1, fsp_pkg::ADDR_RETRY, 32'h33);
		rs(fsp_pkg::ADDR_RETRY);
		cmp("retry write", 32'h33, rd);
		fin("sleep");
		report_and_stop();
	end
endmodule : fsp_fault_supervisor_tb_top
